/* File: e3oh_tx_select.sv */
// Transmit overhead source selection for the E3 frame
//
// Chosen here: the address map and the Avalon-MM register port.
`timescale 1ns/100ps
`include "e3oh_params.svh"
module e3oh_tx_select
  import e3oh_pkg::*;
#(
  parameter logic [7:0] FA1_PATTERN = `E3OH_FA1_PAT,
  parameter logic [7:0] FA2_PATTERN = `E3OH_FA2_PAT
) (
  // Clock, reset and freeze
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        ce,
  // Avalon-MM register slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // Line side
  input  wire logic        tx_line_clk,
  output logic             tx_line_data,
  output logic             tx_frame_pulse,
  // Overhead insertion port
  input  wire logic        tx_overhead_data_in,
  input  wire logic        tx_overhead_insert_en,
  output logic             tx_overhead_clk_out
);
  localparam e3oh_state_s RST = '{bus: E3OH_BUS_WAIT, default: '0};
  localparam logic [12:0] NR_BIT0 = {`E3OH_BYTE_NR, 3'h0};

  e3oh_state_s q;
  e3oh_state_s d;
  e3oh_dl_if   dl ();

  function automatic logic [2:0] pos_kind(input logic [12:0] c);
    case (c[12:3])
      `E3OH_BYTE_FA1: pos_kind = `E3OH_K_FA1;
      `E3OH_BYTE_FA2: pos_kind = `E3OH_K_FA2;
      `E3OH_BYTE_EM:  pos_kind = `E3OH_K_EM;
      `E3OH_BYTE_TR:  pos_kind = `E3OH_K_TR;
      `E3OH_BYTE_MA:  pos_kind = `E3OH_K_MA;
      `E3OH_BYTE_NR:  pos_kind = `E3OH_K_NR;
      `E3OH_BYTE_GC:  pos_kind = `E3OH_K_GC;
      default:        pos_kind = `E3OH_K_PAY;
    endcase
  endfunction

  function automatic logic [31:0] rd_word(input e3oh_state_s s, input logic [5:0] a, input logic full);
    case (a)
      `E3OH_REG_CTRL:   rd_word = {30'h0, s.dl_lapd, s.enable};
      `E3OH_REG_FAMASK: rd_word = {16'h0, s.fa_mask};
      `E3OH_REG_EMMASK: rd_word = {24'h0, s.em_mask};
      `E3OH_REG_MA:     rd_word = {24'h0, s.ma_val};
      `E3OH_REG_TR:     rd_word = {24'h0, s.tr_val};
      `E3OH_REG_NR:     rd_word = {24'h0, s.nr_val};
      `E3OH_REG_GC:     rd_word = {24'h0, s.gc_val};
      `E3OH_REG_LAPD:   rd_word = {31'h0, full};
      `E3OH_REG_STATUS: rd_word = {8'h0, s.bip_last, s.frame_cnt};
      `E3OH_REG_ICOUNT: rd_word = {s.ign_cnt, s.acc_cnt};
      default:          rd_word = 32'h0000_0000;
    endcase
  endfunction

  logic        lclk_rise;
  logic        lclk_fall;
  logic        wrap;
  logic [12:0] nxt_cnt;
  logic [12:0] nxt2_cnt;
  logic [2:0]  kind_n;
  logic [2:0]  kind_n2;
  logic [2:0]  bi_n;
  logic [5:0]  slot_n;
  logic        ins_vld;
  logic        ins_val;
  logic        bit_val;
  logic        tx_bit;
  logic        acceptable;
  logic        wr_ack;

  assign lclk_rise  = q.lclk_s2 & ~q.lclk_prev;
  assign lclk_fall  = ~q.lclk_s2 & q.lclk_prev;
  assign wrap       = (q.bit_cnt == `E3OH_LAST_BIT);
  assign nxt_cnt    = wrap ? 13'h0000 : q.bit_cnt + 13'h0001;
  assign nxt2_cnt   = (nxt_cnt == `E3OH_LAST_BIT) ? 13'h0000 : nxt_cnt + 13'h0001;
  assign kind_n     = pos_kind(nxt_cnt);
  assign kind_n2    = pos_kind(nxt2_cnt);
  assign bi_n       = ~nxt_cnt[2:0];
  assign slot_n     = {3'(kind_n - `E3OH_K_EM), bi_n};
  assign ins_vld    = (kind_n >= `E3OH_K_EM) && q.cur_vld[slot_n];
  assign ins_val    = q.cur_val[slot_n];
  assign tx_bit     = q.enable ? bit_val : 1'b1;
  assign acceptable = q.enable && (kind_n >= `E3OH_K_EM) && !(kind_n == `E3OH_K_NR && q.dl_lapd);
  assign wr_ack     = (q.bus == E3OH_BUS_ACK) && avs_write;

  // Source choice for the bit about to be sent
  always_comb begin
    case (kind_n)
      `E3OH_K_FA1: bit_val = FA1_PATTERN[bi_n] ^ q.fa_mask[8 + bi_n];
      `E3OH_K_FA2: bit_val = FA2_PATTERN[bi_n] ^ q.fa_mask[bi_n];
      `E3OH_K_EM:  bit_val = ins_vld ? ins_val : q.bip_last[bi_n] ^ q.em_mask[bi_n];
      `E3OH_K_TR:  bit_val = ins_vld ? ins_val : q.tr_val[bi_n];
      `E3OH_K_MA:  bit_val = ins_vld ? ins_val : q.ma_val[bi_n];
      `E3OH_K_NR:  bit_val = q.dl_lapd ? q.nr_lapd[bi_n] : (ins_vld ? ins_val : q.nr_val[bi_n]);
      `E3OH_K_GC:  bit_val = ins_vld ? ins_val : q.gc_val[bi_n];
      default:     bit_val = 1'b1;
    endcase
  end

  always_comb begin
    d = q;
    d.lclk_s1   = tx_line_clk;
    d.lclk_s2   = q.lclk_s1;
    d.lclk_prev = q.lclk_s2;
    d.data_s1   = tx_overhead_data_in;
    d.data_s2   = q.data_s1;
    d.ins_s1    = tx_overhead_insert_en;
    d.ins_s2    = q.ins_s1;
    if (lclk_rise) begin
      d.bit_cnt     = nxt_cnt;
      d.line_data   = tx_bit;
      d.frame_pulse = (nxt_cnt == `E3OH_LAST_BIT);
      d.oh_clk      = q.enable && (kind_n2 != `E3OH_K_PAY);
      d.bip_acc     = (wrap ? 8'h00 : q.bip_acc) ^ ({7'h00, tx_bit} << bi_n);
      if (wrap) begin
        d.bip_last  = q.bip_acc;
        d.cur_val   = q.nxt_val;
        d.cur_vld   = q.nxt_vld;
        d.nxt_vld   = '0;
        d.frame_cnt = q.frame_cnt + 16'h0001;
      end
      if (dl.take) begin
        d.nr_lapd = dl.tx_byte;
      end
    end
    if (lclk_fall) begin
      d.oh_clk = 1'b0;
      if (q.oh_clk && q.ins_s2) begin
        if (acceptable) begin
          d.nxt_val[slot_n] = q.data_s2;
          d.nxt_vld[slot_n] = 1'b1;
          d.acc_cnt         = q.acc_cnt + 16'h0001;
        end else begin
          d.ign_cnt = q.ign_cnt + 16'h0001;
        end
      end
    end
    case (q.bus)
      E3OH_BUS_WAIT: begin
        if (avs_read || avs_write) begin
          d.bus   = E3OH_BUS_ACK;
          d.rdata = rd_word(q, avs_address, dl.full);
        end
      end
      E3OH_BUS_ACK: begin
        d.bus = E3OH_BUS_WAIT;
        if (avs_write && avs_byteenable[0]) begin
          case (avs_address)
            `E3OH_REG_CTRL: begin
              d.enable  = avs_writedata[0];
              d.dl_lapd = avs_writedata[1];
            end
            `E3OH_REG_FAMASK: d.fa_mask[7:0] = avs_writedata[7:0];
            `E3OH_REG_EMMASK: d.em_mask      = avs_writedata[7:0];
            `E3OH_REG_MA:     d.ma_val       = avs_writedata[7:0];
            `E3OH_REG_TR:     d.tr_val       = avs_writedata[7:0];
            `E3OH_REG_NR:     d.nr_val       = avs_writedata[7:0];
            `E3OH_REG_GC:     d.gc_val       = avs_writedata[7:0];
            default: d.bus = E3OH_BUS_WAIT;
          endcase
        end
        if (avs_write && avs_byteenable[1] && avs_address == `E3OH_REG_FAMASK) begin
          d.fa_mask[15:8] = avs_writedata[15:8];
        end
      end
      default: d.bus = E3OH_BUS_WAIT;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= RST;
    end else if (ce) begin
      q <= d;
    end
  end

  assign dl.load      = ce && wr_ack && avs_byteenable[0] && avs_address == `E3OH_REG_LAPD;
  assign dl.load_byte = avs_writedata[7:0];
  assign dl.take      = ce && lclk_rise && q.dl_lapd && nxt_cnt == NR_BIT0 - 13'h0001;

  e3oh_lapd_buf u_lapd (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .dl      (dl.buffer)
  );

  assign avs_readdata        = q.rdata;
  assign avs_waitrequest     = q.bus[0];
  assign tx_line_data        = q.line_data;
  assign tx_frame_pulse      = q.frame_pulse;
  assign tx_overhead_clk_out = q.oh_clk;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  fa_fixed_a: assert property (
    ce && lclk_rise && q.enable && kind_n == `E3OH_K_FA1
    |=> q.line_data == $past(FA1_PATTERN[bi_n] ^ q.fa_mask[8 + bi_n])) else $error("FA1 bit wrong");
  em_mask_a: assert property (
    ce && lclk_rise && q.enable && kind_n == `E3OH_K_EM && !ins_vld
    |=> q.line_data == $past(q.bip_last[bi_n] ^ q.em_mask[bi_n])) else $error("EM bit wrong");
  ma_insert_a: assert property (
    ce && lclk_rise && q.enable && kind_n == `E3OH_K_MA && ins_vld
    |=> q.line_data == $past(ins_val)) else $error("MA insertion lost");
  tr_register_a: assert property (
    ce && lclk_rise && q.enable && kind_n == `E3OH_K_TR && !ins_vld
    |=> q.line_data == $past(q.tr_val[bi_n])) else $error("TR register not sent");
  gc_source_a: assert property (
    ce && lclk_rise && q.enable && kind_n == `E3OH_K_GC
    |=> q.line_data == $past(ins_vld ? ins_val : q.gc_val[bi_n])) else $error("GC bit wrong");
  nr_lapd_a: assert property (
    ce && lclk_rise && q.enable && kind_n == `E3OH_K_NR && q.dl_lapd
    |=> q.line_data == $past(q.nr_lapd[bi_n])) else $error("NR not from LAPD");
  clk_lead_a: assert property (
    ce && lclk_rise && q.enable && kind_n2 != `E3OH_K_PAY ##1 ce [*2]
    |-> q.oh_clk ##1 q.oh_clk) else $error("Overhead clock missing");
  sample_a: assert property (
    ce && lclk_fall && q.oh_clk && q.ins_s2 && acceptable
    |=> q.nxt_vld[$past(slot_n)] && q.nxt_val[$past(slot_n)] == $past(q.data_s2)) else $error("Sample lost");
  ignore_a: assert property (
    !(lclk_fall && q.oh_clk && q.ins_s2 && acceptable) |=> $stable(q.nxt_val)) else $error("Stray insertion");
  next_frame_a: assert property (
    ce && lclk_rise && wrap |=> q.cur_vld == $past(q.nxt_vld) && q.nxt_vld == '0) else $error("Frame handover");
  bus_ack_a: assert property (
    (avs_read || avs_write) && avs_waitrequest && ce |=> !avs_waitrequest) else $error("No bus answer");

  accept_c: cover property (ce && lclk_fall && q.oh_clk && q.ins_s2 && acceptable);
  refuse_c: cover property (ce && lclk_fall && q.oh_clk && q.ins_s2 && !acceptable);
  wrap_c:   cover property (ce && lclk_rise && wrap && q.nxt_vld != '0);
  lapd_c:   cover property (dl.take && dl.full);
endmodule

/* File: e3oh_params.svh */
// Constants for the E3 overhead source selector
// Behaviour
// - User link bits come from the overhead input port or a register, never generated inside.
// - Path maintenance link bits come from the LAPD buffer, the overhead port or a register.
// - FA1 and FA2 are always generated inside; port values there are never inserted.
// - Each EM bit uses the internal value, each MA bit the MA register value, or a value inserted through the port.
// - TR, NR and GC are not generated; port insertion or register storage supplies them.
// - Software mask bits alter the sent state of internally generated overhead bits.
// - Configuration can select the LAPD buffer as source of the data link bits.
// - Terminal equipment can insert values at every insertable overhead position.
// - Port data is sampled at falling overhead clock while insert enable is high.
// - Overhead clock rises one bit period before each overhead bit is processed.
// - Insertion at non-insertable bits is ignored; accepted samples go to next frame.
`ifndef E3OH_PARAMS_SVH
`define E3OH_PARAMS_SVH
// Frame geometry, bits sent MSB first
`define E3OH_LAST_BIT    13'h10C7
`define E3OH_BYTE_FA1    10'h000
`define E3OH_BYTE_FA2    10'h001
`define E3OH_BYTE_EM     10'h03C
`define E3OH_BYTE_TR     10'h077
`define E3OH_BYTE_MA     10'h0B2
`define E3OH_BYTE_NR     10'h0ED
`define E3OH_BYTE_GC     10'h128
`define E3OH_SLOTS       40
// Position kinds; insertable kinds start at EM
`define E3OH_K_PAY       3'h0
`define E3OH_K_FA1       3'h1
`define E3OH_K_FA2       3'h2
`define E3OH_K_EM        3'h3
`define E3OH_K_TR        3'h4
`define E3OH_K_MA        3'h5
`define E3OH_K_NR        3'h6
`define E3OH_K_GC        3'h7
// Register byte offsets
`define E3OH_REG_CTRL    6'h00
`define E3OH_REG_FAMASK  6'h04
`define E3OH_REG_EMMASK  6'h08
`define E3OH_REG_MA      6'h0C
`define E3OH_REG_TR      6'h10
`define E3OH_REG_NR      6'h14
`define E3OH_REG_GC      6'h18
`define E3OH_REG_LAPD    6'h1C
`define E3OH_REG_STATUS  6'h20
`define E3OH_REG_ICOUNT  6'h24
// Reset, fill and framing pattern values
`define E3OH_CTRL_RST    2'h0
`define E3OH_LAPD_IDLE   8'h7E
`define E3OH_FA1_PAT     8'hF6
`define E3OH_FA2_PAT     8'h28
`endif

/* File: e3oh_pkg.sv */
// Types for the E3 overhead source selector
`include "e3oh_params.svh"
package e3oh_pkg;
  typedef enum logic [1:0] {E3OH_BUS_WAIT = 2'b01, E3OH_BUS_ACK = 2'b10} e3oh_bus_e;

  typedef struct packed {
    logic                    lclk_s1, lclk_s2, lclk_prev;
    logic                    data_s1, data_s2, ins_s1, ins_s2;
    logic [12:0]             bit_cnt;
    logic                    oh_clk, line_data, frame_pulse;
    logic [`E3OH_SLOTS-1:0]  cur_val, cur_vld, nxt_val, nxt_vld;
    logic [7:0]              bip_acc, bip_last, nr_lapd;
    logic                    enable, dl_lapd;
    logic [15:0]             fa_mask;
    logic [7:0]              em_mask, ma_val, tr_val, nr_val, gc_val;
    e3oh_bus_e               bus;
    logic [31:0]             rdata;
    logic [15:0]             frame_cnt, acc_cnt, ign_cnt;
  } e3oh_state_s;

  typedef struct packed {
    logic [7:0] data;
    logic       full;
    logic [7:0] sent_cnt;
  } e3oh_lapd_s;
endpackage

/* File: e3oh_dl_if.sv */
// Link between the framer and the LAPD byte buffer
`timescale 1ns/100ps
interface e3oh_dl_if;
  logic       load;
  logic [7:0] load_byte;
  logic       take;
  logic [7:0] tx_byte;
  logic       full;
  modport buffer (input load, load_byte, take, output tx_byte, full);
  modport framer (output load, load_byte, take, input tx_byte, full);
endinterface

/* File: e3oh_lapd_buf.sv */
// One-byte LAPD transmit buffer feeding the path maintenance link
`timescale 1ns/100ps
`include "e3oh_params.svh"
module e3oh_lapd_buf
  import e3oh_pkg::*;
(
  // Clock, reset and freeze
  input  wire logic  ref_clk,
  input  wire logic  rst_n,
  input  wire logic  ce,
  // Framer side
  e3oh_dl_if.buffer  dl
);
  e3oh_lapd_s q;
  e3oh_lapd_s d;

  always_comb begin
    d = q;
    if (dl.take && q.full) begin
      d.full     = 1'b0;
      d.sent_cnt = q.sent_cnt + 8'h01;
    end
    if (dl.load) begin
      d.data = dl.load_byte;
      d.full = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce) begin
      q <= d;
    end
  end

  // Idle fill when software has not supplied a byte
  assign dl.tx_byte = q.full ? q.data : `E3OH_LAPD_IDLE;
  assign dl.full    = q.full;

  lapd_load_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && dl.load |=> q.full && q.data == $past(dl.load_byte)) else $error("LAPD byte not held");
  lapd_take_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ce && dl.take && !dl.load |=> !q.full) else $error("LAPD byte not released");
endmodule

/* File: e3oh_te_model.sv */
// Terminal equipment model driving the overhead insertion port
`timescale 1ns/100ps
module e3oh_te_model (
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Bench control
  input  wire logic       ins_on,
  input  wire logic [7:0] pat,
  // Overhead port
  input  wire logic       oh_clk,
  output logic            oh_data = 1'b0,
  output logic            oh_ins_en = 1'b0
);
  logic       clk_q;
  logic [2:0] idx_q;
  logic [2:0] hold_q;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_q     <= 1'b0;
      idx_q     <= 3'h0;
      hold_q    <= 3'h0;
      oh_data   <= 1'b0;
      oh_ins_en <= 1'b0;
    end else begin
      clk_q <= oh_clk;
      if (oh_clk && !clk_q) begin
        oh_data   <= pat[3'h7 - idx_q];
        oh_ins_en <= ins_on;
        idx_q     <= ins_on ? idx_q + 3'h1 : 3'h0;
      end else if (!ins_on) begin
        idx_q <= 3'h0;
      end
      if (!oh_clk && clk_q) begin
        hold_q <= 3'h2;
      end else if (hold_q != 3'h0) begin
        hold_q <= hold_q - 3'h1;
      end
      // Released line shows the inverse of the last bit
      if (hold_q == 3'h1) begin
        oh_data   <= ~oh_data;
        oh_ins_en <= 1'b0;
      end
    end
  end
endmodule

/* File: e3oh_testbench.sv */
// Self-checking bench for the E3 overhead source selector
`timescale 1ns/100ps
`include "e3oh_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        tx_line_clk = 1'b0;
  logic        tx_line_data;
  logic        tx_frame_pulse;
  logic        tx_overhead_data_in;
  logic        tx_overhead_insert_en;
  logic        tx_overhead_clk_out;
  logic        run_q = 1'b0;
  logic        ins_on = 1'b0;
  logic [2:0]  div_q = 3'h0;
  int          bit_k = 0;
  int          fail_count = 0;
  int          n_tests = 0;
  logic [31:0] seed = 32'hA20DB2F7;
  logic [31:0] rd;
  logic [7:0]  pat = 8'h00;
  logic [7:0]  lapd, v, emmask, em0;
  logic [7:0]  bip = 8'h00;
  logic [7:0]  regv [4];
  logic [15:0] famask;
  logic        bv [4296];

  always #12.5 ref_clk = ~ref_clk;

  e3oh_tx_select dut_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .ce(1'b1),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tx_line_clk(tx_line_clk), .tx_line_data(tx_line_data), .tx_frame_pulse(tx_frame_pulse),
    .tx_overhead_data_in(tx_overhead_data_in), .tx_overhead_insert_en(tx_overhead_insert_en),
    .tx_overhead_clk_out(tx_overhead_clk_out)
  );

  e3oh_te_model te_u (
    .ref_clk(ref_clk), .rst_n(rst_n), .ins_on(ins_on), .pat(pat),
    .oh_clk(tx_overhead_clk_out), .oh_data(tx_overhead_data_in), .oh_ins_en(tx_overhead_insert_en)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  function automatic logic is_oh(input int b);
    case (b / 8)
      0, 1, 60, 119, 178, 237, 296: return 1'b1;
      default:                      return 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] exp_byte(input int b);
    case (b)
      0:            return `E3OH_FA1_PAT ^ famask[15:8];
      1:            return `E3OH_FA2_PAT ^ famask[7:0];
      60, 178, 296: return pat;
      119:          return regv[1];
      237:          return lapd;
      default:      return 8'hFF;
    endcase
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] wd, output logic [31:0] r);
    int n;
    n = 0;
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    r = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (avs_waitrequest !== 1'b0) begin
      fail_count++;
      end_of_test();
    end
    @(posedge ref_clk);
  endtask

  task automatic wait_bit(input int b);
    int n;
    n = 0;
    while (bit_k < b && n < 80000) begin
      @(posedge ref_clk);
      n++;
    end
    if (bit_k < b) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // Line clock of 200 ns; frame capture and overhead clock check at each fall
  always @(posedge ref_clk) begin
    if (run_q) begin
      div_q <= div_q + 3'h1;
      if (div_q == 3'h0) begin
        tx_line_clk <= 1'b1;
        bit_k <= bit_k + 1;
      end
      if (div_q == 3'h4) begin
        tx_line_clk <= 1'b0;
        if (bit_k >= 4296 && bit_k < 8592) bv[bit_k - 4296] = tx_line_data;
        // First frame EM byte carries only the mask, no parity yet
        if (bit_k >= 480 && bit_k < 488) em0 <= {em0[6:0], tx_line_data};
        `CHK(tx_overhead_clk_out, is_oh((bit_k + 1) % 4296))
        `CHK(tx_frame_pulse, (bit_k % 4296) == 4295)
      end
    end
  end

  initial begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, 6'(i * 4), 32'h0, rd);
      `CHK(rd, 32'h0)
    end
    seed = xs(seed);
    famask = seed[15:0];
    pat = seed[23:16];
    lapd = seed[31:24];
    bus(1'b1, `E3OH_REG_FAMASK, {16'h0000, famask}, rd);
    seed = xs(seed);
    emmask = seed[7:0];
    bus(1'b1, `E3OH_REG_EMMASK, seed, rd);
    for (int i = 0; i < 4; i++) begin
      seed = xs(seed);
      regv[i] = seed[7:0];
      bus(1'b1, `E3OH_REG_MA + 6'(i * 4), seed, rd);
      bus(1'b0, `E3OH_REG_MA + 6'(i * 4), 32'h0, rd);
      `CHK(rd, {24'h000000, regv[i]})
    end
    bus(1'b1, 6'h3C, 32'hFFFFFFFF, rd);
    bus(1'b0, 6'h3C, 32'h0, rd);
    `CHK(rd, 32'h0)
    bus(1'b1, `E3OH_REG_CTRL, 32'h3, rd);
    ins_on <= 1'b1;
    run_q  <= 1'b1;
    wait_bit(20);
    ins_on <= 1'b0;
    wait_bit(400);
    ins_on <= 1'b1;
    wait_bit(600);
    ins_on <= 1'b0;
    wait_bit(1000);
    ins_on <= 1'b1;
    wait_bit(2000);
    bus(1'b1, `E3OH_REG_LAPD, {24'h000000, lapd}, rd);
    bus(1'b0, `E3OH_REG_LAPD, 32'h0, rd);
    `CHK(rd, 32'h1)
    wait_bit(4200);
    ins_on <= 1'b0;
    bus(1'b0, `E3OH_REG_ICOUNT, 32'h0, rd);
    `CHK(rd, {16'h0016, 16'h0018})
    wait_bit(8593);
    for (int b = 0; b < 537; b++) begin
      for (int j = 0; j < 8; j++) v = {v[6:0], bv[b * 8 + j]};
      `CHK(v, exp_byte(b))
      bip = bip ^ v;
    end
    bus(1'b0, `E3OH_REG_STATUS, 32'h0, rd);
    `CHK(rd, {8'h00, bip, 16'h0002})
    `CHK(em0, emmask)
    bus(1'b0, `E3OH_REG_LAPD, 32'h0, rd);
    `CHK(rd, 32'h0)
    end_of_test();
  end
endmodule
